// File: pps_supervisor.sv
// Phase and power-state supervisor of a multiphase buck controller.
// Assumes a command-code register port already decoded from the serial
// bus, a synchronous external converter, and mV readings of the output.
`timescale 1ns/1ps
`include "pps_defs.svh"
module pps_supervisor (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Load and supply status
  input wire logic low_power_state_n_in,
  input wire logic supply_lockout_ok_in,
  input wire logic [2:0] phase_count_in,
  input wire logic modulator_good_in,
  // Output voltage and its target in mV
  input wire logic [11:0] vout_mv_in,
  input wire logic [11:0] vid_mv_in,
  // Modulator PWM and outputs to gate drivers
  input wire logic [5:0] pwm_in,
  output logic [5:0] pwm_out,
  output logic shed_phase_disable_n_out,
  output logic always_on_phase_disable_n_out,
  output logic output_good_out,
  // Status flags
  output logic thermal_hot_flag_out,
  output logic thermal_warn_out,
  output logic crowbar_active_out,
  // Converter
  input wire logic adc_done_in,
  input wire logic [9:0] adc_data_in,
  output pps_pkg::pps_chan_e adc_chan_out,
  output logic adc_start_out,
  // Register port
  input wire pps_pkg::pps_reg_req_s reg_req_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_rvalid_out
);

  logic [7:0] overtemp_fault_limit;
  logic [7:0] overtemp_warn_limit;
  logic [7:0] manufacturer_config;
  logic [1:0] pgood_high_code;
  logic [15:0] thermistor_gain;
  logic [15:0] thermistor_offset;
  logic [15:0] temperature_result;
  logic [15:0] input_voltage_result;
  logic [9:0] enable_result;
  logic [9:0] voltage_sense_b_result;
  logic sample_valid;
  pps_pkg::pps_sample_s sample;
  logic running;
  logic crowbar;
  logic [5:0] full_mask;
  logic [5:0] low_power_mask;
  logic [5:0] next_phase_mask;
  logic [12:0] crowbar_limit_mv;
  logic [12:0] crowbar_trip_mv;
  logic [25:0] temp_product;
  logic [15:0] next_temperature;
  logic [15:0] next_rdata;

  ////////////////////////////////////////////////////////////////////
  // Converter sequencer
  pps_adc_seq u_adc_seq (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .adc_done_in(adc_done_in),
    .adc_data_in(adc_data_in),
    .adc_chan_out(adc_chan_out),
    .adc_start_out(adc_start_out),
    .sample_valid_out(sample_valid),
    .sample_out(sample)
  );

  ////////////////////////////////////////////////////////////////////
  // Writable registers, one block each
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      overtemp_fault_limit <= `PPS_OT_FAULT_RST;
    end else if (reg_req_in.wr && reg_req_in.cmd == `PPS_CMD_OT_FAULT) begin
      overtemp_fault_limit <= reg_req_in.wdata[7:0];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      overtemp_warn_limit <= `PPS_OT_WARN_RST;
    end else if (reg_req_in.wr && reg_req_in.cmd == `PPS_CMD_OT_WARN) begin
      overtemp_warn_limit <= reg_req_in.wdata[7:0];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      manufacturer_config <= `PPS_MFR_CFG_RST;
    end else if (reg_req_in.wr && reg_req_in.cmd == `PPS_CMD_MFR_CFG) begin
      manufacturer_config <= reg_req_in.wdata[7:0];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      pgood_high_code <= `PPS_PGOOD_HI_RST;
    end else if (reg_req_in.wr && reg_req_in.cmd == `PPS_CMD_PGOOD_HI) begin
      pgood_high_code <= reg_req_in.wdata[`PPS_PGOOD_HI_MSB:0];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      thermistor_gain <= `PPS_TH_GAIN_RST;
    end else if (reg_req_in.wr && reg_req_in.cmd == `PPS_CMD_TH_GAIN) begin
      thermistor_gain <= reg_req_in.wdata;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      thermistor_offset <= `PPS_TH_OFFS_RST;
    end else if (reg_req_in.wr && reg_req_in.cmd == `PPS_CMD_TH_OFFS) begin
      thermistor_offset <= reg_req_in.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Measurement results, each replaced whole on its own sample
  assign temp_product = sample.code * thermistor_gain;
  assign next_temperature = temp_product[15:0] + thermistor_offset;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      temperature_result <= 16'h0000;
    end else if (sample_valid && sample.chan == pps_pkg::PPS_CH_THERM) begin
      temperature_result <= next_temperature;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      enable_result <= 10'h000;
    end else if (sample_valid && sample.chan == pps_pkg::PPS_CH_EN) begin
      enable_result <= sample.code;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      input_voltage_result <= 16'h0000;
    end else if (sample_valid && sample.chan == pps_pkg::PPS_CH_VSA) begin
      input_voltage_result <= {3'h0, sample.code, 3'h0};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      voltage_sense_b_result <= 10'h000;
    end else if (sample_valid && sample.chan == pps_pkg::PPS_CH_VSB) begin
      voltage_sense_b_result <= sample.code;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read port, answer one cycle after the strobe
  always_comb begin
    next_rdata = 16'h0000;
    if (reg_req_in.cmd == `PPS_CMD_OT_FAULT) begin
      next_rdata = {8'h00, overtemp_fault_limit};
    end else if (reg_req_in.cmd == `PPS_CMD_OT_WARN) begin
      next_rdata = {8'h00, overtemp_warn_limit};
    end else if (reg_req_in.cmd == `PPS_CMD_MFR_CFG) begin
      next_rdata = {8'h00, manufacturer_config};
    end else if (reg_req_in.cmd == `PPS_CMD_PGOOD_HI) begin
      next_rdata = {14'h0000, pgood_high_code};
    end else if (reg_req_in.cmd == `PPS_CMD_TH_GAIN) begin
      next_rdata = thermistor_gain;
    end else if (reg_req_in.cmd == `PPS_CMD_TH_OFFS) begin
      next_rdata = thermistor_offset;
    end else if (reg_req_in.cmd == `PPS_CMD_READ_TEMP) begin
      next_rdata = temperature_result;
    end else if (reg_req_in.cmd == `PPS_CMD_INPUT_VOLTAGE_RESULT) begin
      next_rdata = input_voltage_result;
    end else if (reg_req_in.cmd == `PPS_CMD_READ_EN) begin
      next_rdata = {6'h00, enable_result};
    end else if (reg_req_in.cmd == `PPS_CMD_READ_VSB) begin
      next_rdata = {6'h00, voltage_sense_b_result};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      reg_rdata_out <= 16'h0000;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_req_in.rd;
      if (reg_req_in.rd) begin
        reg_rdata_out <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Enable and lockout gate
  assign running = supply_lockout_ok_in
    && (enable_result > 10'(`PPS_EN_ON_CODE));

  ////////////////////////////////////////////////////////////////////
  // Crowbar with hysteresis
  assign crowbar_limit_mv = 13'(`PPS_CROWBAR_BASE_MV)
    - 13'(`PPS_CROWBAR_STEP_MV) * {11'h000, pgood_high_code};
  assign crowbar_trip_mv = {1'b0, vid_mv_in} + crowbar_limit_mv;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      crowbar <= 1'b0;
    end else if ({1'b0, vout_mv_in} > crowbar_trip_mv) begin
      crowbar <= 1'b1;
    end else if (vout_mv_in < 12'(`PPS_CROWBAR_RELEASE_MV)) begin
      crowbar <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Phase selection
  function automatic logic [5:0] pps_full_mask(input logic [2:0] count);
    logic [5:0] mask;
    mask = 6'h00;
    for (int i = 0; i < 6; i++) begin
      if (3'(i) < count) begin
        mask[i] = 1'b1;
      end
    end
    if (count == 3'h0) begin
      mask = `PPS_MASK_P1;
    end
    return mask;
  endfunction

  function automatic logic [5:0] pps_low_mask(input logic [2:0] count,
                                              input logic [1:0] code);
    logic [5:0] mask;
    mask = `PPS_MASK_P1;
    if (count == 3'h6 && code == 2'h1) begin
      mask = `PPS_MASK_P1_P4;
    end else if (count == 3'h6 && code == 2'h2) begin
      mask = `PPS_MASK_P1_P3_P5;
    end else if (count == 3'h5 && code == 2'h1) begin
      mask = `PPS_MASK_P1_P4;
    end else if (count == 3'h4 && code == 2'h1) begin
      mask = `PPS_MASK_P1_P3;
    end
    return mask;
  endfunction

  assign full_mask = pps_full_mask(phase_count_in);
  assign low_power_mask = pps_low_mask(phase_count_in,
    manufacturer_config[`PPS_MFR_PSI_MSB:`PPS_MFR_PSI_LSB]);
  assign next_phase_mask = low_power_state_n_in ? full_mask : low_power_mask;

  ////////////////////////////////////////////////////////////////////
  // PWM gating, one bit per phase
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_pwm
      always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
          pwm_out[g] <= 1'b0;
        end else begin
          pwm_out[g] <= pwm_in[g] && next_phase_mask[g] && running
            && !crowbar;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Driver disables and power-good
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      shed_phase_disable_n_out <= 1'b0;
    end else begin
      shed_phase_disable_n_out <= running && low_power_state_n_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      always_on_phase_disable_n_out <= 1'b0;
    end else begin
      always_on_phase_disable_n_out <= running;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      output_good_out <= 1'b0;
    end else begin
      output_good_out <= running && modulator_good_in && !crowbar;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Thermal and crowbar flags
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      thermal_hot_flag_out <= 1'b0;
    end else begin
      thermal_hot_flag_out <= temperature_result > {8'h00, overtemp_fault_limit};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      thermal_warn_out <= 1'b0;
    end else begin
      thermal_warn_out <= temperature_result > {8'h00, overtemp_warn_limit};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      crowbar_active_out <= 1'b0;
    end else begin
      crowbar_active_out <= crowbar;
    end
  end

endmodule

// File: pps_defs.svh
// Constants of the phase and power-state supervisor: command codes,
// field positions, reset values and analog thresholds.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef PPS_DEFS_SVH
`define PPS_DEFS_SVH

// Command codes of the register port
`define PPS_CMD_OT_FAULT 8'h51
`define PPS_CMD_OT_WARN 8'h52
`define PPS_CMD_PGOOD_HI 8'hE0
`define PPS_CMD_MFR_CFG 8'hD1
`define PPS_CMD_TH_GAIN 8'hF7
`define PPS_CMD_TH_OFFS 8'hF8
`define PPS_CMD_INPUT_VOLTAGE_RESULT 8'h88
`define PPS_CMD_READ_TEMP 8'h8D
`define PPS_CMD_READ_EN 8'hD4
`define PPS_CMD_READ_VSB 8'hD5

// Field positions
`define PPS_MFR_PSI_MSB 7
`define PPS_MFR_PSI_LSB 6
`define PPS_PGOOD_HI_MSB 1

// Reset values
`define PPS_MFR_CFG_RST 8'h00
`define PPS_OT_FAULT_RST 8'h64
`define PPS_OT_WARN_RST 8'h5A
`define PPS_TH_GAIN_RST 16'h0001
`define PPS_TH_OFFS_RST 16'h0000
`define PPS_PGOOD_HI_RST 2'h0

// Analog figures in millivolts, converter codes and the input divider ratio
`define PPS_ADC_FULL_SCALE_MV 2000
`define PPS_ADC_MAX_CODE 1023
`define PPS_EN_THRESHOLD_MV 800
`define PPS_EN_ON_CODE ((`PPS_EN_THRESHOLD_MV * `PPS_ADC_MAX_CODE) / `PPS_ADC_FULL_SCALE_MV)
`define PPS_CROWBAR_BASE_MV 300
`define PPS_CROWBAR_STEP_MV 50
`define PPS_CROWBAR_RELEASE_MV 300
`define PPS_VIN_DIVIDER 8

// Phase masks, bit 0 is phase 1
`define PPS_MASK_P1 6'h01
`define PPS_MASK_P1_P4 6'h09
`define PPS_MASK_P1_P3 6'h05
`define PPS_MASK_P1_P3_P5 6'h15

`endif

// File: pps_pkg.sv
// Types shared by the supervisor and its converter sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package pps_pkg;

  typedef enum logic [3:0] {
    PPS_CH_THERM = 4'h1,
    PPS_CH_EN = 4'h2,
    PPS_CH_VSA = 4'h4,
    PPS_CH_VSB = 4'h8
  } pps_chan_e;

  typedef enum logic [2:0] {
    PPS_SEQ_IDLE = 3'h1,
    PPS_SEQ_START = 3'h2,
    PPS_SEQ_WAIT = 3'h4
  } pps_seq_state_e;

  typedef struct packed {
    pps_chan_e chan;
    logic [9:0] code;
  } pps_sample_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } pps_reg_req_s;

endpackage

// File: pps_adc_seq.sv
// Round-robin sequencer for the external converter: thermistor,
// enable, sense A, sense B, then again.
// Assumes the converter answers each start with one done pulse.
`timescale 1ns/1ps
module pps_adc_seq (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Converter side
  input wire logic adc_done_in,
  input wire logic [9:0] adc_data_in,
  output pps_pkg::pps_chan_e adc_chan_out,
  output logic adc_start_out,
  // Sample side
  output logic sample_valid_out,
  output pps_pkg::pps_sample_s sample_out
);

  pps_pkg::pps_seq_state_e state;

  ////////////////////////////////////////////////////////////////////
  // Sequence state
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state <= pps_pkg::PPS_SEQ_IDLE;
    end else begin
      case (state)
        pps_pkg::PPS_SEQ_IDLE: state <= pps_pkg::PPS_SEQ_START;
        pps_pkg::PPS_SEQ_START: state <= pps_pkg::PPS_SEQ_WAIT;
        pps_pkg::PPS_SEQ_WAIT: begin
          if (adc_done_in) begin
            state <= pps_pkg::PPS_SEQ_START;
          end
        end
        default: state <= pps_pkg::PPS_SEQ_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Start pulse and channel order
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      adc_start_out <= 1'b0;
    end else begin
      adc_start_out <= (state == pps_pkg::PPS_SEQ_START);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      adc_chan_out <= pps_pkg::PPS_CH_THERM;
    end else if (state == pps_pkg::PPS_SEQ_WAIT && adc_done_in) begin
      case (adc_chan_out)
        pps_pkg::PPS_CH_THERM: adc_chan_out <= pps_pkg::PPS_CH_EN;
        pps_pkg::PPS_CH_EN: adc_chan_out <= pps_pkg::PPS_CH_VSA;
        pps_pkg::PPS_CH_VSA: adc_chan_out <= pps_pkg::PPS_CH_VSB;
        default: adc_chan_out <= pps_pkg::PPS_CH_THERM;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Finished sample, one-cycle valid
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      sample_valid_out <= 1'b0;
      sample_out <= '0;
    end else begin
      sample_valid_out <= (state == pps_pkg::PPS_SEQ_WAIT) && adc_done_in;
      if (state == pps_pkg::PPS_SEQ_WAIT && adc_done_in) begin
        sample_out.chan <= adc_chan_out;
        sample_out.code <= adc_data_in;
      end
    end
  end

endmodule

// File: pps_adc_model.sv
// Converter model: answers each start with one done pulse.
// Assumes one start per conversion; bus shows inverse data when idle.
`timescale 1ns/1ps
module pps_adc_model #(parameter int LAT = 3) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Converter port
  input wire logic adc_start_in,
  input wire pps_pkg::pps_chan_e adc_chan_in,
  output logic adc_done_out,
  output logic [9:0] adc_data_out,
  // Analog codes
  input wire logic [9:0] therm_in,
  input wire logic [9:0] en_in,
  input wire logic [9:0] vsa_in,
  input wire logic [9:0] vsb_in
);
  int cnt;
  logic [9:0] held;
  logic [9:0] last;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      cnt <= 0;
      adc_done_out <= 1'b0;
      adc_data_out <= 10'h3ff;
      last <= 10'h000;
    end else begin
      adc_done_out <= 1'b0;
      adc_data_out <= ~last;
      if (adc_start_in) begin
        cnt <= LAT;
        case (adc_chan_in)
          pps_pkg::PPS_CH_THERM: held <= therm_in;
          pps_pkg::PPS_CH_EN: held <= en_in;
          pps_pkg::PPS_CH_VSA: held <= vsa_in;
          default: held <= vsb_in;
        endcase
      end else if (cnt == 1) begin
        cnt <= 0;
        adc_done_out <= 1'b1;
        adc_data_out <= held;
        last <= held;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// File: pps_supervisor_chk.sv
// Port checker for the supervisor.
// Assumes binding to pps_supervisor.
`timescale 1ns/1ps
module pps_supervisor_chk (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Watched inputs
  input wire logic low_power_state_n_in,
  input wire logic supply_lockout_ok_in,
  input wire logic modulator_good_in,
  input wire logic [11:0] vout_mv_in,
  input wire logic [11:0] vid_mv_in,
  input wire pps_pkg::pps_reg_req_s reg_req_in,
  // Watched outputs
  input wire logic [5:0] pwm_out,
  input wire logic shed_phase_disable_n_out,
  input wire logic always_on_phase_disable_n_out,
  input wire logic output_good_out,
  input wire logic crowbar_active_out,
  input wire pps_pkg::pps_chan_e adc_chan_out,
  input wire logic adc_start_out,
  input wire logic reg_rvalid_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  logic [3:0] last_chan;
  logic seen;
  // Channel of the previous start
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      seen <= 1'b0;
      last_chan <= 4'h0;
    end else if (adc_start_out) begin
      seen <= 1'b1;
      last_chan <= adc_chan_out;
    end
  end
  property p_shed; !low_power_state_n_in |=> !shed_phase_disable_n_out; endproperty
  a_shed: assert property (p_shed) else $error("shed disable high in low power");
  property p_restore;
    low_power_state_n_in ##1 always_on_phase_disable_n_out |-> shed_phase_disable_n_out;
  endproperty
  a_restore: assert property (p_restore) else $error("shed phases not restored");
  property p_psi_set; !low_power_state_n_in |=> (pwm_out & 6'h22) == 6'h00; endproperty
  a_psi_set: assert property (p_psi_set) else $error("phase 2 or 6 runs in low power");
  property p_off;
    !supply_lockout_ok_in |=> pwm_out == 6'h00 && !output_good_out
      && !shed_phase_disable_n_out && !always_on_phase_disable_n_out;
  endproperty
  a_off: assert property (p_off) else $error("outputs active under lockout");
  property p_good; output_good_out |-> always_on_phase_disable_n_out && $past(modulator_good_in);
  endproperty
  a_good: assert property (p_good) else $error("power good while stopped");
  property p_cb_pwm; crowbar_active_out [*2] |-> pwm_out == 6'h00; endproperty
  a_cb_pwm: assert property (p_cb_pwm) else $error("pwm active in crowbar");
  property p_cb_set;
    ({1'b0, vout_mv_in} > {1'b0, vid_mv_in} + 13'h012c) [*3] |-> crowbar_active_out;
  endproperty
  a_cb_set: assert property (p_cb_set) else $error("crowbar missed");
  property p_cb_clr;
    (vout_mv_in < 12'h12c && vid_mv_in >= 12'h12c) [*3] |-> !crowbar_active_out;
  endproperty
  a_cb_clr: assert property (p_cb_clr) else $error("crowbar not released");
  property p_rvalid; reg_rvalid_out == $past(reg_req_in.rd); endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer misplaced");
  property p_start; adc_start_out |=> !adc_start_out; endproperty
  a_start: assert property (p_start) else $error("start pulse too long");
  property p_rr; adc_start_out && seen |-> adc_chan_out == {last_chan[2:0], last_chan[3]};
  endproperty
  a_rr: assert property (p_rr) else $error("channel out of order");
  c_crowbar: cover property (crowbar_active_out [*2]);
  c_psi: cover property (!low_power_state_n_in ##1 !shed_phase_disable_n_out);
  c_read: cover property (reg_req_in.rd ##1 reg_rvalid_out);
endmodule
bind pps_supervisor pps_supervisor_chk u_chk (
  .clk_sys_in(clk_sys_in), .reset_in(reset_in), .low_power_state_n_in(low_power_state_n_in),
  .supply_lockout_ok_in(supply_lockout_ok_in), .modulator_good_in(modulator_good_in),
  .vout_mv_in(vout_mv_in), .vid_mv_in(vid_mv_in), .reg_req_in(reg_req_in), .pwm_out(pwm_out),
  .shed_phase_disable_n_out(shed_phase_disable_n_out), .output_good_out(output_good_out),
  .always_on_phase_disable_n_out(always_on_phase_disable_n_out),
  .crowbar_active_out(crowbar_active_out), .adc_chan_out(adc_chan_out),
  .adc_start_out(adc_start_out), .reg_rvalid_out(reg_rvalid_out));

// File: pps_supervisor_tb_top.sv
// Self-checking bench for the supervisor with a converter model.
// Assumes the checker is bound to the supervisor.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module pps_supervisor_tb_top;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic lp_n = 1'b1;
  logic lock_ok = 1'b1;
  logic [2:0] nph = 3'h6;
  logic [11:0] vout = 12'h3e8;
  logic [11:0] vid = 12'h3e8;
  logic [9:0] c_en = 10'h258;
  logic mod_good = 1'b1;
  logic [5:0] pwm_src = 6'h3f;
  pps_pkg::pps_reg_req_s req = '0;
  logic adc_done, adc_start, rvalid, shed_n, aon_n, good, hot, warn, cb;
  logic [9:0] adc_data;
  pps_pkg::pps_chan_e adc_chan;
  logic [15:0] rdata;
  logic [5:0] pwm_out;
  logic [10:0] tab [11] = '{11'h601, 11'h649, 11'h695, 11'h6c1, 11'h549, 11'h581,
    11'h445, 11'h401, 11'h341, 11'h281, 11'h1c1};
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  pps_supervisor DUT (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .low_power_state_n_in(lp_n), .supply_lockout_ok_in(lock_ok), .phase_count_in(nph),
    .modulator_good_in(mod_good), .vout_mv_in(vout), .vid_mv_in(vid), .pwm_in(pwm_src),
    .pwm_out(pwm_out), .shed_phase_disable_n_out(shed_n), .always_on_phase_disable_n_out(aon_n),
    .output_good_out(good), .thermal_hot_flag_out(hot), .thermal_warn_out(warn),
    .crowbar_active_out(cb), .adc_done_in(adc_done), .adc_data_in(adc_data),
    .adc_chan_out(adc_chan), .adc_start_out(adc_start), .reg_req_in(req),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid));
  pps_adc_model u_adc (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .adc_start_in(adc_start),
    .adc_chan_in(adc_chan), .adc_done_out(adc_done), .adc_data_out(adc_data),
    .therm_in(10'h064), .en_in(c_en), .vsa_in(10'h0c8), .vsb_in(10'h14d));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_sys_in);
    req <= '{1'b1, 1'b0, c, d};
    @(posedge clk_sys_in);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] ex);
    @(posedge clk_sys_in);
    req <= '{1'b0, 1'b1, c, 16'h0000};
    cyc(1);
    req <= '0;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", ex, rdata)
  endtask
  task automatic finish_test;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    cyc(5);
    reset_in <= 1'b0;
    rd(8'h51, 16'h0064);
    rd(8'h52, 16'h005a);
    rd(8'hd1, 16'h0000);
    rd(8'he0, 16'h0000);
    rd(8'hf7, 16'h0001);
    rd(8'hf8, 16'h0000);
    rd(8'h00, 16'h0000);
    wr(8'hd1, 16'h01c0);
    rd(8'hd1, 16'h00c0);
    wr(8'he0, 16'h0007);
    rd(8'he0, 16'h0003);
    cyc(60);
    rd(8'hd4, 16'h0258);
    rd(8'hd5, 16'h014d);
    rd(8'h88, 16'h0640);
    rd(8'h8d, 16'h0064);
    wr(8'h88, 16'h1234);
    rd(8'h88, 16'h0640);
    wr(8'hf7, 16'h0002);
    wr(8'hf8, 16'h0007);
    wr(8'h51, 16'h00cf);
    cyc(60);
    rd(8'h8d, 16'h00cf);
    `CHK("hot", 1'b0, hot)
    `CHK("warn", 1'b1, warn)
    wr(8'h51, 16'h00ce);
    cyc(3);
    `CHK("hot", 1'b1, hot)
    wr(8'h52, 16'h00cf);
    rd(8'h52, 16'h00cf);
    `CHK("warn", 1'b0, warn)
    for (int i = 0; i < 11; i++) begin
      nph <= tab[i][10:8];
      wr(8'hd1, {8'h00, tab[i][7:6], 6'h00});
      lp_n <= 1'b0;
      cyc(3);
      `CHK("psi pwm", tab[i][5:0], pwm_out)
      `CHK("shed", 1'b0, shed_n)
      `CHK("always on", 1'b1, aon_n)
      lp_n <= 1'b1;
      cyc(1);
      `CHK("full pwm", 6'h3f >> (3'h6 - tab[i][10:8]), pwm_out)
      `CHK("shed", 1'b1, shed_n)
    end
    nph <= 3'h6;
    wr(8'he0, 16'h0000);
    vout <= 12'h515;
    cyc(3);
    `CHK("crowbar", 7'h40, {cb, pwm_out})
    `CHK("good", 1'b0, good)
    vout <= 12'h3e8;
    cyc(3);
    `CHK("crowbar", 1'b1, cb)
    vout <= 12'h12b;
    cyc(3);
    `CHK("crowbar", 1'b0, cb)
    wr(8'he0, 16'h0003);
    vout <= 12'h47e;
    cyc(3);
    `CHK("crowbar", 1'b0, cb)
    vout <= 12'h47f;
    cyc(3);
    `CHK("crowbar", 1'b1, cb)
    vout <= 12'h12b;
    cyc(3);
    lock_ok <= 1'b0;
    cyc(2);
    `CHK("off", 9'h000, {pwm_out, good, shed_n, aon_n})
    lock_ok <= 1'b1;
    c_en <= 10'h199;
    cyc(60);
    `CHK("off", 9'h000, {pwm_out, good, shed_n, aon_n})
    c_en <= 10'h19a;
    cyc(60);
    `CHK("on", 9'h1ff, {pwm_out, good, shed_n, aon_n})
    pwm_src <= 6'h2a;
    mod_good <= 1'b0;
    cyc(2);
    `CHK("gated pwm and good", 7'h54, {pwm_out, good})
    finish_test();
  end
endmodule
